// ==== hw/lcs_cmd_regs.vh ====
// command codes, parameter byte counts, reset defaults and register offsets of the command sequencer
`ifndef LCS_CMD_REGS_VH
`define LCS_CMD_REGS_VH

// register offsets (byte addresses)
`define LCS_OFF_CMD        12'h000
`define LCS_OFF_DATA       12'h004
`define LCS_OFF_STATE      12'h008
`define LCS_OFF_DISP       12'h00C
`define LCS_OFF_VOL        12'h010
`define LCS_OFF_SCROLL     12'h014
`define LCS_OFF_WINDOW     12'h018
`define LCS_OFF_PIXEL      12'h01C
`define LCS_OFF_LUT        12'h020

// command codes
`define LCS_CMD_DISP_CTRL  8'hCA
`define LCS_CMD_COM_SCAN   8'hBB
`define LCS_CMD_OSC_ON     8'hD1
`define LCS_CMD_OSC_OFF    8'hD2
`define LCS_CMD_SLP_EXIT   8'h94
`define LCS_CMD_SLP_ENTER  8'h95
`define LCS_CMD_VOLUME     8'h81
`define LCS_CMD_TMP_SLOPE  8'h82
`define LCS_CMD_PWR        8'h20
`define LCS_CMD_DISP_NORM  8'hA6
`define LCS_CMD_DISP_INV   8'hA7
`define LCS_CMD_PTL_ENTER  8'hA8
`define LCS_CMD_PTL_EXIT   8'hA9
`define LCS_CMD_SCR_REGION 8'hAA
`define LCS_CMD_SCR_ORIGIN 8'hAB
`define LCS_CMD_DATA_ORDER 8'hBC
`define LCS_CMD_COLOR_LUT  8'hCE
`define LCS_CMD_ROW_WIN    8'h75
`define LCS_CMD_COL_WIN    8'h15
`define LCS_CMD_FRAME_WR   8'h5C
`define LCS_CMD_DISP_ON    8'hAF
`define LCS_CMD_DISP_OFF   8'hAE
`define LCS_CMD_NOP        8'h25

// parameter byte counts
`define LCS_NPAR_DISP_CTRL  4'h3
`define LCS_NPAR_COM_SCAN   4'h1
`define LCS_NPAR_VOLUME     4'h2
`define LCS_NPAR_TMP_SLOPE  4'h1
`define LCS_NPAR_PWR        4'h1
`define LCS_NPAR_PTL        4'h2
`define LCS_NPAR_SCR_REGION 4'h4
`define LCS_NPAR_SCR_ORIGIN 4'h1
`define LCS_NPAR_DATA_ORDER 4'h3
`define LCS_NPAR_COLOR_LUT  5'h14
`define LCS_NPAR_WINDOW     4'h2

// reset defaults
`define LCS_RST_CLK_DIV    2'h0
`define LCS_RST_DUTY       8'h00
`define LCS_RST_INV_LINES  8'h11
`define LCS_RST_COM_SCAN   3'h0
`define LCS_RST_VOLUME     6'h00
`define LCS_RST_RES_RATIO  3'h0
`define LCS_RST_TMP_SLOPE  2'h0
`define LCS_RST_PWR        4'h0
`define LCS_RST_DATA_ORDER 8'h00
`define LCS_RST_GRAD_8     3'h1

// interface select codes on the three select pins
`define LCS_IFSEL_PAR16    3'h4
`define LCS_IFSEL_SER9     3'h1

`endif

// ==== hw/lcs_cmd_fifo_lut.v ====
// colour-position lookup table of the command sequencer
`timescale 1ns/10ps
module lcs_cmd_fifo_lut (
  clk,
  rst,
  wrEn,
  wrIdx,
  wrData,
  rdIdx,
  rdData
);
  input  wire       clk;
  input  wire       rst;
  input  wire       wrEn;
  input  wire [4:0] wrIdx;
  input  wire [3:0] wrData;
  input  wire [4:0] rdIdx;
  output reg  [3:0] rdData;

  reg [3:0] lut_reg [0:19];

  // each entry clears on reset and loads on its own write
  genvar i;
  generate
    for (i = 0; i < 20; i = i + 1) begin : gEntry
      always @(posedge clk) begin
        if (rst) begin
          lut_reg[i] <= 4'h0; // RL10
        end else if (wrEn && wrIdx == i) begin
          lut_reg[i] <= wrData;
        end
      end
    end
  endgenerate

  // combinational read port, so the bus can register it with the request
  always @* begin
    if (rdIdx < 5'h14) begin
      rdData = lut_reg[rdIdx];
    end else begin
      rdData = 4'h0;
    end
  end
endmodule

// ==== hw/lcs_command_sequencer.v ====
// command interpreter and state holder of the colour display driver, AXI4-Lite register face
//
// Summary of operation
// RL1: reset: divide two, duty 1/4, inversion 11h
// RL2: reset: common scan forward, rows 1-160
// RL3: reset: oscillator off, device asleep
// RL4: reset: contrast zero, resistor ratio zero
// RL5: reset: temperature slope selection zero
// RL6: reset: all drive-power blocks disabled
// RL7: reset: full display, fixed area zero
// RL8: reset: scroll region, type, origin zero
// RL9: reset: normal addressing, RGB, 8 levels
// RL10: reset: colour lookup entries all zero
// RL11: reset: write window addresses all zero
// RL12: frame write takes data until next command
// RL13: host waits 100ms before display-on
// RL14: sleep shorts drive supply to ground
// RL15: display-off drives outputs to mid level
// RL16: oscillator-off halts internal clocked circuits
// RL17: host shutdown order before supply removal
// RL18: host may shut down via reset
// RL19: sleep keeps memory, settings, accepts commands; sleep entry here clears the display-on, power and oscillator settings
// RL20: host wake order: exit, osc, wait, on
// RL21: host refreshes settings periodically
// RL22: host asserts reset after power-up
// RL23: select pins choose 16-bit or 9-bit interface
// RL24: apply setting only after all parameters; colour lookup entries load as each parameter arrives
`timescale 1ns/10ps
`include "lcs_cmd_regs.vh"
module lcs_command_sequencer (
  clk,
  rst,
  ifaceSel,
  s_axi_awaddr,
  s_axi_awvalid,
  s_axi_awready,
  s_axi_wdata,
  s_axi_wstrb,
  s_axi_wvalid,
  s_axi_wready,
  s_axi_bresp,
  s_axi_bvalid,
  s_axi_bready,
  s_axi_araddr,
  s_axi_arvalid,
  s_axi_arready,
  s_axi_rdata,
  s_axi_rresp,
  s_axi_rvalid,
  s_axi_rready,
  pixelData,
  pixelValid,
  displayOn,
  outputsMidLevel,
  oscRunning,
  sleepActive,
  driveShort,
  powerEnable,
  wide16Mode
);
  input  wire        clk;
  input  wire        rst;
  input  wire [2:0]  ifaceSel;
  input  wire [11:0] s_axi_awaddr;
  input  wire        s_axi_awvalid;
  output wire        s_axi_awready;
  input  wire [31:0] s_axi_wdata;
  input  wire [3:0]  s_axi_wstrb;
  input  wire        s_axi_wvalid;
  output wire        s_axi_wready;
  output wire [1:0]  s_axi_bresp;
  output reg         s_axi_bvalid;
  input  wire        s_axi_bready;
  input  wire [11:0] s_axi_araddr;
  input  wire        s_axi_arvalid;
  output wire        s_axi_arready;
  output reg  [31:0] s_axi_rdata;
  output reg  [1:0]  s_axi_rresp;
  output reg         s_axi_rvalid;
  input  wire        s_axi_rready;
  output reg  [15:0] pixelData;
  output reg         pixelValid;
  output wire        displayOn;
  output wire        outputsMidLevel;
  output wire        oscRunning;
  output wire        sleepActive;
  output wire        driveShort;
  output wire [3:0]  powerEnable;
  output wire        wide16Mode;

  // parser states
  localparam ST_IDLE  = 2'h0;
  localparam ST_PARAM = 2'h1;
  localparam ST_FRAME = 2'h2;

  reg [1:0]  state_reg;
  reg [7:0]  curCmd_reg;
  reg [4:0]  parIdx_reg;
  reg [7:0]  par_reg [0:3];
  reg        awHeld_reg;
  reg [11:0] awAddr_reg;
  reg        wHeld_reg;
  reg [31:0] wData_reg;
  reg        bErr_reg;
  reg        wide16_reg;

  // settings
  reg [1:0]  clkDiv_reg;
  reg [7:0]  duty_reg;
  reg [7:0]  invLines_reg;
  reg [2:0]  comScan_reg;
  reg        osc_reg;
  reg        sleep_reg;
  reg        dispOn_reg;
  reg        dispInv_reg;
  reg [5:0]  volume_reg;
  reg [2:0]  resRatio_reg;
  reg [1:0]  tmpSlope_reg;
  reg [3:0]  pwr_reg;
  reg        partial_reg;
  reg [7:0]  ptlStart_reg;
  reg [7:0]  ptlEnd_reg;
  reg [7:0]  scrTop_reg;
  reg [7:0]  scrBot_reg;
  reg [7:0]  scrCount_reg;
  reg [1:0]  scrType_reg;
  reg [7:0]  scrOrigin_reg;
  reg [2:0]  dataOrder_reg;
  reg        bgrOrder_reg;
  reg [2:0]  grad_reg;
  reg [7:0]  rowStart_reg;
  reg [7:0]  rowEnd_reg;
  reg [7:0]  colStart_reg;
  reg [7:0]  colEnd_reg;

  wire       wrFire;
  wire [7:0] wByte;
  wire       cmdWrite;
  wire       dataWrite;
  wire       addrOk;
  reg  [4:0] needPar;
  wire       lastPar;
  wire [3:0] lutRdData;
  wire       lutHit;

  // write address and data accepted in either order, one at a time
  assign s_axi_awready = !awHeld_reg && !s_axi_bvalid;
  assign s_axi_wready  = !wHeld_reg && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign s_axi_bresp   = bErr_reg ? 2'h2 : 2'h0;
  assign wrFire        = awHeld_reg && wHeld_reg;
  assign wByte         = wData_reg[7:0];
  assign addrOk        = awAddr_reg == `LCS_OFF_CMD || awAddr_reg == `LCS_OFF_DATA;
  assign cmdWrite      = wrFire && awAddr_reg == `LCS_OFF_CMD;
  assign dataWrite     = wrFire && awAddr_reg == `LCS_OFF_DATA;
  // twenty lookup words from the lookup offset upward
  assign lutHit        = s_axi_araddr >= `LCS_OFF_LUT && s_axi_araddr < `LCS_OFF_LUT + 12'h050;

  // parameter count per command
  always @* begin
    case (curCmd_reg)
      `LCS_CMD_DISP_CTRL:  needPar = {1'b0, `LCS_NPAR_DISP_CTRL};
      `LCS_CMD_COM_SCAN:   needPar = {1'b0, `LCS_NPAR_COM_SCAN};
      `LCS_CMD_VOLUME:     needPar = {1'b0, `LCS_NPAR_VOLUME};
      `LCS_CMD_TMP_SLOPE:  needPar = {1'b0, `LCS_NPAR_TMP_SLOPE};
      `LCS_CMD_PWR:        needPar = {1'b0, `LCS_NPAR_PWR};
      `LCS_CMD_PTL_ENTER:  needPar = {1'b0, `LCS_NPAR_PTL};
      `LCS_CMD_SCR_REGION: needPar = {1'b0, `LCS_NPAR_SCR_REGION};
      `LCS_CMD_SCR_ORIGIN: needPar = {1'b0, `LCS_NPAR_SCR_ORIGIN};
      `LCS_CMD_DATA_ORDER: needPar = {1'b0, `LCS_NPAR_DATA_ORDER};
      `LCS_CMD_COLOR_LUT:  needPar = `LCS_NPAR_COLOR_LUT;
      `LCS_CMD_ROW_WIN:    needPar = {1'b0, `LCS_NPAR_WINDOW};
      `LCS_CMD_COL_WIN:    needPar = {1'b0, `LCS_NPAR_WINDOW};
      default:             needPar = 5'd0;
    endcase
  end
  assign lastPar = dataWrite && state_reg == ST_PARAM && parIdx_reg == needPar - 5'd1;

  // colour lookup entries
  lcs_cmd_fifo_lut uLut (
    .clk    (clk),
    .rst    (rst),
    .wrEn   (dataWrite && state_reg == ST_PARAM && curCmd_reg == `LCS_CMD_COLOR_LUT),
    .wrIdx  (parIdx_reg),
    .wrData (wByte[3:0]),
    .rdIdx  (s_axi_araddr[6:2] - 5'd8),
    .rdData (lutRdData)
  );

  // AXI write channel capture and response
  always @(posedge clk) begin
    if (rst) begin
      awHeld_reg   <= 1'b0;
      awAddr_reg   <= 12'h000;
      wHeld_reg    <= 1'b0;
      wData_reg    <= 32'h00000000;
      s_axi_bvalid <= 1'b0;
      bErr_reg     <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_reg <= 1'b1;
        awAddr_reg <= {s_axi_awaddr[11:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_reg <= 1'b1;
        wData_reg <= s_axi_wstrb[0] ? s_axi_wdata : {s_axi_wdata[31:8], 8'h00};
      end
      if (wrFire) begin
        awHeld_reg   <= 1'b0;
        wHeld_reg    <= 1'b0;
        s_axi_bvalid <= 1'b1;
        bErr_reg     <= !addrOk;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // interface width follows the select pins whenever the parser is idle and no write fires
  always @(posedge clk) begin
    if (rst) begin
      wide16_reg <= 1'b0;
    end else if (state_reg == ST_IDLE && !wrFire) begin
      wide16_reg <= ifaceSel == `LCS_IFSEL_PAR16; // RL23
    end
  end
  assign wide16Mode = wide16_reg;

  // command parser and setting update
  always @(posedge clk) begin
    if (rst) begin // RL22
      state_reg     <= ST_IDLE;
      curCmd_reg    <= 8'h00;
      parIdx_reg    <= 5'd0;
      par_reg[0]    <= 8'h00;
      par_reg[1]    <= 8'h00;
      par_reg[2]    <= 8'h00;
      par_reg[3]    <= 8'h00;
      clkDiv_reg    <= `LCS_RST_CLK_DIV; // RL1
      duty_reg      <= `LCS_RST_DUTY; // RL1
      invLines_reg  <= `LCS_RST_INV_LINES; // RL1
      comScan_reg   <= `LCS_RST_COM_SCAN; // RL2
      osc_reg       <= 1'b0; // RL3
      sleep_reg     <= 1'b1; // RL3
      dispOn_reg    <= 1'b0;
      dispInv_reg   <= 1'b0;
      volume_reg    <= `LCS_RST_VOLUME; // RL4
      resRatio_reg  <= `LCS_RST_RES_RATIO; // RL4
      tmpSlope_reg  <= `LCS_RST_TMP_SLOPE; // RL5
      pwr_reg       <= `LCS_RST_PWR; // RL6
      partial_reg   <= 1'b0; // RL7
      ptlStart_reg  <= 8'h00; // RL7
      ptlEnd_reg    <= 8'h00; // RL7
      scrTop_reg    <= 8'h00; // RL8
      scrBot_reg    <= 8'h00; // RL8
      scrCount_reg  <= 8'h00; // RL8
      scrType_reg   <= 2'h0; // RL8
      scrOrigin_reg <= 8'h00; // RL8
      dataOrder_reg <= 3'h0; // RL9
      bgrOrder_reg  <= 1'b0; // RL9
      grad_reg      <= `LCS_RST_GRAD_8; // RL9
      rowStart_reg  <= 8'h00; // RL11
      rowEnd_reg    <= 8'h00; // RL11
      colStart_reg  <= 8'h00; // RL11
      colEnd_reg    <= 8'h00; // RL11
      pixelData     <= 16'h0000;
      pixelValid    <= 1'b0;
    end else begin
      pixelValid <= 1'b0;
      if (cmdWrite) begin
        // any command ends a frame burst or an unfinished parameter list
        curCmd_reg <= wByte; // RL12
        parIdx_reg <= 5'd0;
        state_reg  <= ST_IDLE;
        case (wByte)
          `LCS_CMD_FRAME_WR:  state_reg <= ST_FRAME; // RL12
          `LCS_CMD_OSC_ON:    osc_reg <= 1'b1;
          `LCS_CMD_OSC_OFF:   osc_reg <= 1'b0; // RL16
          `LCS_CMD_SLP_EXIT:  sleep_reg <= 1'b0;
          `LCS_CMD_SLP_ENTER: begin
            // sleep stops display, power and oscillator only
            sleep_reg  <= 1'b1; // RL19
            dispOn_reg <= 1'b0;
            pwr_reg    <= 4'h0;
            osc_reg    <= 1'b0;
          end
          `LCS_CMD_DISP_NORM: dispInv_reg <= 1'b0;
          `LCS_CMD_DISP_INV:  dispInv_reg <= 1'b1;
          `LCS_CMD_PTL_EXIT:  partial_reg <= 1'b0;
          `LCS_CMD_DISP_ON:   dispOn_reg <= 1'b1;
          `LCS_CMD_DISP_OFF:  dispOn_reg <= 1'b0; // RL15
          `LCS_CMD_DISP_CTRL, `LCS_CMD_COM_SCAN, `LCS_CMD_VOLUME, `LCS_CMD_TMP_SLOPE,
          `LCS_CMD_PWR, `LCS_CMD_PTL_ENTER, `LCS_CMD_SCR_REGION, `LCS_CMD_SCR_ORIGIN,
          `LCS_CMD_DATA_ORDER, `LCS_CMD_COLOR_LUT, `LCS_CMD_ROW_WIN, `LCS_CMD_COL_WIN:
            state_reg <= ST_PARAM; // RL24
          default: state_reg <= ST_IDLE;
        endcase
      end else if (dataWrite) begin
        case (state_reg)
          ST_FRAME: begin
            pixelData  <= wide16_reg ? wData_reg[15:0] : {8'h00, wByte}; // RL12
            pixelValid <= 1'b1;
          end
          ST_PARAM: begin
            if (parIdx_reg < 5'd4) begin
              par_reg[parIdx_reg[1:0]] <= wByte;
            end
            parIdx_reg <= parIdx_reg + 5'd1;
            if (lastPar) begin
              // apply only once the whole list is in
              state_reg <= ST_IDLE; // RL24
              case (curCmd_reg)
                `LCS_CMD_DISP_CTRL: begin
                  clkDiv_reg   <= par_reg[0][1:0];
                  duty_reg     <= par_reg[1];
                  invLines_reg <= wByte;
                end
                `LCS_CMD_COM_SCAN:   comScan_reg <= wByte[2:0];
                `LCS_CMD_VOLUME: begin
                  volume_reg   <= par_reg[0][5:0];
                  resRatio_reg <= wByte[2:0];
                end
                `LCS_CMD_TMP_SLOPE:  tmpSlope_reg <= wByte[1:0];
                `LCS_CMD_PWR:        pwr_reg <= sleep_reg ? 4'h0 : wByte[3:0]; // RL14
                `LCS_CMD_PTL_ENTER: begin
                  partial_reg  <= 1'b1;
                  ptlStart_reg <= par_reg[0];
                  ptlEnd_reg   <= wByte;
                end
                `LCS_CMD_SCR_REGION: begin
                  scrTop_reg   <= par_reg[0];
                  scrBot_reg   <= par_reg[1];
                  scrCount_reg <= par_reg[2];
                  scrType_reg  <= wByte[1:0];
                end
                `LCS_CMD_SCR_ORIGIN: scrOrigin_reg <= wByte;
                `LCS_CMD_DATA_ORDER: begin
                  dataOrder_reg <= par_reg[0][2:0];
                  bgrOrder_reg  <= par_reg[1][0];
                  grad_reg      <= wByte[2:0];
                end
                `LCS_CMD_ROW_WIN: begin
                  rowStart_reg <= par_reg[0];
                  rowEnd_reg   <= wByte;
                end
                `LCS_CMD_COL_WIN: begin
                  colStart_reg <= par_reg[0];
                  colEnd_reg   <= wByte;
                end
                default: state_reg <= ST_IDLE;
              endcase
            end
          end
          default: state_reg <= ST_IDLE;
        endcase
      end
    end
  end

  // drive outputs follow oscillator, sleep and display state
  assign oscRunning      = osc_reg;
  assign sleepActive     = sleep_reg;
  assign driveShort      = sleep_reg; // RL14
  assign powerEnable     = (sleep_reg || !osc_reg) ? 4'h0 : pwr_reg; // RL16
  assign displayOn       = dispOn_reg && osc_reg && !sleep_reg;
  assign outputsMidLevel = !displayOn; // RL15

  // AXI read channel
  always @(posedge clk) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= 2'h0;
      case ({s_axi_araddr[11:2], 2'b00})
        `LCS_OFF_CMD:    s_axi_rdata <= {24'h000000, curCmd_reg};
        `LCS_OFF_DATA:   s_axi_rdata <= {16'h0000, pixelData};
        `LCS_OFF_STATE:  s_axi_rdata <= {19'h00000, wide16_reg, pwr_reg, partial_reg, dispInv_reg,
                                         dispOn_reg, sleep_reg, osc_reg, 1'b0, state_reg};
        `LCS_OFF_DISP:   s_axi_rdata <= {11'h000, comScan_reg, clkDiv_reg, duty_reg, invLines_reg};
        `LCS_OFF_VOL:    s_axi_rdata <= {11'h000, grad_reg, bgrOrder_reg, dataOrder_reg,
                                         tmpSlope_reg, resRatio_reg, 3'h0, volume_reg};
        `LCS_OFF_SCROLL: s_axi_rdata <= {scrTop_reg, scrBot_reg, scrCount_reg[5:0], scrType_reg, scrOrigin_reg};
        `LCS_OFF_WINDOW: s_axi_rdata <= {rowStart_reg, rowEnd_reg, colStart_reg, colEnd_reg};
        `LCS_OFF_PIXEL:  s_axi_rdata <= {ptlStart_reg, ptlEnd_reg, 16'h0000};
        default: begin
          // lookup entries read back in the low nibble, anything else is an error
          s_axi_rdata <= lutHit ? {28'h0000000, lutRdData} : 32'h00000000; // RL10
          s_axi_rresp <= lutHit ? 2'h0 : 2'h2;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule

// ==== verif/lcs_seq_assertions.sv ====
// assertion checker on the command sequencer ports
`timescale 1ns/10ps
module lcs_seq_assertions (
  input wire       clk,
  input wire       rst,
  input wire [2:0] ifaceSel,
  input wire       s_axi_awvalid,
  input wire       s_axi_awready,
  input wire       s_axi_wvalid,
  input wire       s_axi_wready,
  input wire       s_axi_bvalid,
  input wire       pixelValid,
  input wire       displayOn,
  input wire       outputsMidLevel,
  input wire       oscRunning,
  input wire       sleepActive,
  input wire       driveShort,
  input wire [3:0] powerEnable,
  input wire       wide16Mode
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // state relations and response timing
  reset_state_a: assert property ($fell(rst) |-> sleepActive && !oscRunning && powerEnable == 4'h0 && !displayOn)
    else $error("state after reset wrong");
  sleep_short_a: assert property (driveShort == sleepActive && (sleepActive -> powerEnable == 4'h0))
    else $error("drive short or power wrong in sleep");
  mid_level_a: assert property (outputsMidLevel == !displayOn)
    else $error("outputs not at mid level when display off");
  osc_halt_a: assert property (!oscRunning |-> powerEnable == 4'h0 && !displayOn)
    else $error("activity with oscillator stopped");
  disp_source_a: assert property (displayOn |-> oscRunning && !sleepActive)
    else $error("display on without oscillator or while asleep");
  pix_at_resp_a: assert property (pixelValid |-> $rose(s_axi_bvalid) ##1 !pixelValid)
    else $error("pixel strobe not tied to a write response");
  apply_at_resp_a: assert property ($changed(powerEnable) || $changed(displayOn) |-> $rose(s_axi_bvalid))
    else $error("setting changed outside a write response");
  write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  wide_sel_a: assert property (!$past(rst) |-> wide16Mode == ($past(ifaceSel) == 3'h4))
    else $error("interface width does not follow select pins");
  cover property (pixelValid);
  cover property ($rose(displayOn));
  cover property ($rose(sleepActive));
endmodule

bind lcs_command_sequencer lcs_seq_assertions chk (.clk(clk), .rst(rst), .ifaceSel(ifaceSel),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .pixelValid(pixelValid),
  .displayOn(displayOn), .outputsMidLevel(outputsMidLevel), .oscRunning(oscRunning),
  .sleepActive(sleepActive), .driveShort(driveShort), .powerEnable(powerEnable), .wide16Mode(wide16Mode));

// ==== verif/lcs_host_model.sv ====
// AXI4-Lite host model issuing commands and frame data
`timescale 1ns/10ps
module lcs_host_model (
  input  wire        clk,
  output reg  [11:0] awaddr = 12'h000,
  output reg         awvalid = 1'b0,
  input  wire        awready,
  output reg  [31:0] wdata = 32'h00000000,
  output wire [3:0]  wstrb,
  output reg         wvalid = 1'b0,
  input  wire        wready,
  input  wire [1:0]  bresp,
  input  wire        bvalid,
  output wire        bready,
  output reg  [11:0] araddr = 12'h000,
  output reg         arvalid = 1'b0,
  input  wire        arready,
  input  wire [31:0] rdata,
  input  wire [1:0]  rresp,
  input  wire        rvalid,
  output wire        rready
);
  integer lag = 0;     // idle cycles before a write request, for a slow host
  reg     hung = 1'b0; // an answer never came
  // responses always accepted, all lanes written
  assign bready = 1'b1;
  assign rready = 1'b1;
  assign wstrb = 4'hF;
  // one write: address and data together, each released when taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    integer n;
    n = 0;
    repeat (lag) @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge clk);
      n = n + 1;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid && n < 200);
    hung = hung | (n >= 200);
    r = bresp;
  endtask
  // one read
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    integer n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge clk);
      n = n + 1;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid && n < 200);
    hung = hung | (n >= 200);
    d = rdata;
    r = rresp;
  endtask
endmodule

// ==== verif/test_lcs_command_sequencer.sv ====
// self-checking bench for the command sequencer
`timescale 1ns/10ps
module test_lcs_command_sequencer;
  typedef struct {bit w; logic [11:0] a; logic [31:0] d; logic [31:0] m; logic [1:0] s;} lcs_row_t;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [2:0]  ifaceSel = 3'h1;
  wire         awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  wire  [11:0] awaddr, araddr;
  wire  [31:0] wdata, rdata;
  wire  [3:0]  wstrb, powerEnable;
  wire  [1:0]  bresp, rresp;
  wire  [15:0] pixelData;
  wire         pixelValid, displayOn, outputsMidLevel, oscRunning, sleepActive, driveShort, wide16Mode;
  lcs_row_t    rows[$];
  integer      n_mismatch = 0;
  integer      cmp_count = 0;
  integer      pixCnt = 0;
  integer      n0;
  logic [15:0] lastPix = 16'h0000;
  logic [31:0] rdv;
  logic [1:0]  rs;
  localparam int SETTLE = 20; // short stand-in for the supply settling wait

  lcs_command_sequencer dut (
    .clk(clk), .rst(rst), .ifaceSel(ifaceSel),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .pixelData(pixelData), .pixelValid(pixelValid), .displayOn(displayOn),
    .outputsMidLevel(outputsMidLevel), .oscRunning(oscRunning), .sleepActive(sleepActive),
    .driveShort(driveShort), .powerEnable(powerEnable), .wide16Mode(wide16Mode));

  lcs_host_model host (
    .clk(clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready));

  // 200 MHz clock
  initial begin
    forever #2.5 clk = ~clk;
  end
  // count frame data strobes and keep the last word
  always @(posedge clk) begin
    if (pixelValid === 1'b1) begin
      pixCnt <= pixCnt + 1;
      lastPix <= pixelData;
    end
  end
  // a stuck handshake ends the run
  always @(posedge clk) begin
    if (host.hung) begin
      n_mismatch = n_mismatch + 1;
      stop_test;
    end
  end

  task stop_test;
    $display("comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count = cmp_count + 1;
    if (g !== e) begin
      n_mismatch = n_mismatch + 1;
      $display("MISMATCH at %0t: got %h, want %h", $time, g, e);
    end
  endtask
  task add(input bit w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] m, input logic [1:0] s);
    rows.push_back('{w, a, d, m, s});
  endtask
  task cmd(input logic [7:0] c);
    add(1, 12'h000, {24'h0, c}, 32'h0, 2'h0);
  endtask
  task par(input logic [7:0] x);
    add(1, 12'h004, {24'h0, x}, 32'h0, 2'h0);
  endtask
  task look(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
    add(0, a, e, m, 2'h0);
  endtask
  task put(input logic [11:0] a, input logic [31:0] d);
    host.wr(a, d, rs);
    chk({30'h0, rs}, 32'h0);
  endtask
  task do_reset(input logic [2:0] sel);
    rst <= 1'b1;
    ifaceSel <= sel;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
  endtask

  initial begin
    look(12'h008, 32'h10, 32'h1FF8);
    look(12'h00C, 32'h11, 32'h1FFFFF);
    look(12'h010, 32'h40000, 32'h1FFE3F);
    look(12'h014, 32'h0, 32'hFFFFFFFF);
    look(12'h018, 32'h0, 32'hFFFFFFFF);
    look(12'h01C, 32'h0, 32'hFFFFFFFF);
    look(12'h020, 32'h0, 32'hFFFFFFFF);
    add(0, 12'h100, 32'h0, 32'hFFFFFFFF, 2'h2);
    add(1, 12'h100, 32'hAF, 32'h0, 2'h2);
    cmd(8'h20);
    par(8'h0F);
    look(12'h008, 32'h10, 32'h1FF8);
    cmd(8'h94);
    cmd(8'hD1);
    look(12'h008, 32'h08, 32'h1FF8);
    cmd(8'h20);
    par(8'h0F);
    add(1, 12'hFFF, 32'h0, 32'h0, 2'h0);
    cmd(8'hAF);
    look(12'h008, 32'hF28, 32'h1FF8);
    cmd(8'h75);
    par(8'h12);
    par(8'h34);
    cmd(8'h15);
    par(8'h56);
    par(8'h78);
    look(12'h018, 32'h12345678, 32'hFFFFFFFF);
    cmd(8'hCE);
    for (int k = 0; k < 20; k++)
      par(k[7:0]);
    look(12'h034, 32'h5, 32'hFFFFFFFF);
    cmd(8'h81);
    par(8'h05);
    look(12'h010, 32'h40000, 32'h1FFE3F);
    par(8'h03);
    look(12'h010, 32'h40605, 32'h1FFE3F);
    cmd(8'h81);
    par(8'h07);
    cmd(8'h25);
    par(8'h09);
    look(12'h010, 32'h40605, 32'h1FFE3F);
    cmd(8'hAE);
    look(12'h008, 32'hF08, 32'h1FF8);
    cmd(8'h20);
    par(8'h00);
    look(12'h008, 32'h008, 32'h1FF8);
    cmd(8'hD2);
    look(12'h008, 32'h000, 32'h1FF8);
    cmd(8'h95);
    look(12'h008, 32'h010, 32'h1FF8);
    look(12'h010, 32'h40605, 32'h1FFE3F);
    cmd(8'h81);
    par(8'h0A);
    par(8'h01);
    look(12'h010, 32'h4020A, 32'h1FFE3F);
    do_reset(3'h1);
    foreach (rows[i]) begin
      if (rows[i].a == 12'hFFF) begin
        repeat (SETTLE) @(posedge clk);
      end else if (rows[i].w) begin
        host.wr(rows[i].a, rows[i].d, rs);
        chk({30'h0, rs}, {30'h0, rows[i].s});
      end else begin
        host.rd(rows[i].a, rdv, rs);
        chk(rdv & rows[i].m, rows[i].d);
        chk({30'h0, rs}, {30'h0, rows[i].s});
      end
    end
    // frame data burst from a slow host, ended by another command
    n0 = pixCnt;
    put(12'h000, 32'h5C);
    host.lag = 2;
    put(12'h004, 32'h1234A5);
    host.lag = 0;
    put(12'h004, 32'h5A);
    put(12'h000, 32'h25);
    put(12'h004, 32'h77);
    @(posedge clk);
    chk(pixCnt - n0, 32'h2);
    chk({16'h0, lastPix}, 32'h5A);
    // second reset mid-run with the 16-bit interface selected
    do_reset(3'h4);
    @(posedge clk);
    chk({24'h0, wide16Mode, sleepActive, oscRunning, displayOn, powerEnable}, 32'hC0);
    host.rd(12'h010, rdv, rs);
    chk(rdv & 32'h1FFE3F, 32'h40000);
    host.rd(12'h034, rdv, rs);
    chk(rdv, 32'h0);
    put(12'h000, 32'h5C);
    put(12'h004, 32'hBEEF);
    @(posedge clk);
    chk({16'h0, lastPix}, 32'hBEEF);
    stop_test;
  end
endmodule
